// ===== logic/adc_channel_trigger_control.sv
/*
 * control logic of a 12-bit successive-approximation converter:
 * clock gate, clock source select, channel decode, triggers, result
 * shaping, compare and completion flag.
 * assumes: the analog core presents its code on ANA_DATA_I when a
 * conversion ends; all inputs are synchronous to CLK_I.
 */
// Implementation choices: the register offsets and the plain strobed port.
// Operation
// - clock gate bit set after reset
// - cleared gate stops module clock
// - pin codes 0, 4-11, 12 decoded
// - reserved codes still convert, result undefined
// - internal channel codes decoded
// - four conversion clock sources
// - alternate clock is external reference out
// - time-of-day match starts conversion
// - trigger not gated by match interrupt
// - trigger works in low-power modes
// - single and continuous conversion
// - 12, 10, 8 bit right-justified results
// - compare less-than or greater-or-equal
// - keeps running in wait, partial stop
// - up to 28 inputs by channel select
// - all-ones code powers down, ends continuous
// - control write aborts and restarts
// - done flag set and clear
// - interrupt when done and enabled
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_channel_trigger_control #(
    parameter logic [4:0] CONV_TICKS = `CONV_TICKS
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // register port
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // conversion clock sources
    input wire logic ASYNC_CONV_CLOCK_I,
    input wire logic EXT_REF_CLOCK_OUT_I,
    // time-of-day unit
    input wire logic TOD_MATCH_I,
    // analog core
    input wire logic [11:0] ANA_DATA_I,
    output logic BUS_CLK_EN_O,
    output logic CONV_ACTIVE_O,
    output logic POWER_DOWN_O,
    output logic [4:0] CHANNEL_O,
    output logic [12:0] PIN_EN_O,
    output logic [6:0] INT_SEL_O,
    output logic RESERVED_O,
    // interrupt
    output logic IRQ_O
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [4:0] ch_q;
    logic irq_en_q;
    logic cont_q;
    logic done_q;
    logic done_d;
    logic trig_sel_q;
    logic cmp_en_q;
    logic cmp_ge_q;
    logic [1:0] mode_q;
    logic [1:0] src_q;
    logic [11:0] res_q;
    logic [11:0] cv_q;
    logic gate_q;
    logic [7:0] rdata_q;
    adc_ctrl_pkg::conv_state_e st_q;
    adc_ctrl_pkg::conv_state_e st_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic tick;
    logic [11:0] shaped;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // writes to the module need its clock, except the gate itself
    wire wr_any = WR_I & gate_q;
    wire wr_sc1 = wr_any && (ADDR_I == `OFS_STAT_CTRL_1);
    wire wr_sc2 = wr_any && (ADDR_I == `OFS_STAT_CTRL_2);
    wire wr_cfg = wr_any && (ADDR_I == `OFS_CONFIG);
    wire wr_cvh = wr_any && (ADDR_I == `OFS_CMP_HIGH);
    wire wr_cvl = wr_any && (ADDR_I == `OFS_CMP_LOW);
    wire wr_gate = WR_I && (ADDR_I == `OFS_CLOCK_GATE);
    wire rd_resl = RD_I && (ADDR_I == `OFS_RESULT_LOW);
    wire sw_start = wr_sc1 && (WDATA_I[4:0] != `CH_OFF);

    // ------------------------------------------------------------
    // channel decode
    // ------------------------------------------------------------
    wire ch_off = (ch_q == `CH_OFF);
    logic [12:0] pin_hit;
    localparam logic [12:0] PIN_MAP_L = `PIN_MAP;
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++) begin : g_pin
            assign pin_hit[gi] = (ch_q == 5'(gi)) && PIN_MAP_L[gi];
        end
    endgenerate
    // internal sources; reference high and low
    assign INT_SEL_O[0] = (ch_q == `CH_REF_OUT);
    assign INT_SEL_O[1] = (ch_q == `CH_BIAS);
    assign INT_SEL_O[2] = (ch_q == `CH_LEVEL_ONE);
    assign INT_SEL_O[3] = (ch_q == `CH_TEMP);
    assign INT_SEL_O[4] = (ch_q == `CH_BANDGAP);
    assign INT_SEL_O[5] = (ch_q == `CH_REF_HIGH);
    assign INT_SEL_O[6] = (ch_q == `CH_REF_LOW);
    assign PIN_EN_O = pin_hit;
    // reserved codes flagged, but conversion proceeds
    assign RESERVED_O = ~|pin_hit & ~|INT_SEL_O & ~ch_off;
    // selected input code to the analog mux
    assign CHANNEL_O = ch_q;
    // all ones isolates and powers down
    assign POWER_DOWN_O = ch_off;

    // ------------------------------------------------------------
    // conversion clock
    // ------------------------------------------------------------
    // source select; alternate is external reference out
    conv_tick_gen u_tick (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .src_i(src_q),
        .async_clk_i(ASYNC_CONV_CLOCK_I),
        .alt_clk_i(EXT_REF_CLOCK_OUT_I),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // engine
    // ------------------------------------------------------------
    // match starts conversion; no interrupt enable in the path
    wire hw_start = TOD_MATCH_I && trig_sel_q && (st_q == adc_ctrl_pkg::ST_IDLE) && !ch_off;
    wire finish = (st_q == adc_ctrl_pkg::ST_CONV) && tick && (cnt_q == CONV_TICKS - 5'h01);
    // a finish in the cycle of a control write is aborted by it
    wire finish_ok = finish && !wr_sc1 && gate_q;

    always_comb begin
        case (adc_ctrl_pkg::res_mode_e'(mode_q))
            adc_ctrl_pkg::MODE_12: shaped = ANA_DATA_I;
            adc_ctrl_pkg::MODE_10: shaped = {2'h0, ANA_DATA_I[11:2]};
            adc_ctrl_pkg::MODE_8: shaped = {4'h0, ANA_DATA_I[11:4]};
            default: shaped = {4'h0, ANA_DATA_I[11:4]};
        endcase
    end

    wire cmp_true = cmp_ge_q ? (shaped >= cv_q) : (shaped < cv_q);
    // completion counts only if compare holds when enabled
    wire done_set = finish_ok && (!cmp_en_q || cmp_true);

    // next state of the engine
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (!gate_q) begin
            // no module clock, engine frozen idle
            st_d = adc_ctrl_pkg::ST_IDLE;
            cnt_d = 5'h00;
        end else if (wr_sc1) begin
            // abort and restart; all ones just stops
            st_d = sw_start ? adc_ctrl_pkg::ST_CONV : adc_ctrl_pkg::ST_IDLE;
            cnt_d = 5'h00;
        end else if (hw_start) begin
            st_d = adc_ctrl_pkg::ST_CONV;
            cnt_d = 5'h00;
        end else if (finish) begin
            // continuous reruns, single drops to idle
            st_d = cont_q ? adc_ctrl_pkg::ST_CONV : adc_ctrl_pkg::ST_IDLE;
            cnt_d = 5'h00;
        end else if ((st_q == adc_ctrl_pkg::ST_CONV) && tick) begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    // set wins over a result read in the same cycle
    assign done_d = done_set | (done_q & ~wr_sc1 & ~rd_resl);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q <= adc_ctrl_pkg::ST_IDLE;
            cnt_q <= 5'h00;
            done_q <= 1'b0;
            res_q <= 12'h000;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            if (done_set) begin
                res_q <= shaped;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // gate comes out of reset set
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            gate_q <= `RST_GATE;
        end else if (wr_gate) begin
            gate_q <= WDATA_I[`BIT_GATE];
        end
    end

    // control and configuration fields
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ch_q <= `RST_CHANNEL;
            irq_en_q <= 1'b0;
            cont_q <= 1'b0;
            trig_sel_q <= 1'b0;
            cmp_en_q <= 1'b0;
            cmp_ge_q <= 1'b0;
            mode_q <= 2'h0;
            src_q <= 2'h0;
            cv_q <= 12'h000;
        end else begin
            if (wr_sc1) begin
                ch_q <= WDATA_I[4:0];
                irq_en_q <= WDATA_I[`BIT_IRQ_EN];
                cont_q <= WDATA_I[`BIT_CONT];
            end
            if (wr_sc2) begin
                trig_sel_q <= WDATA_I[`BIT_HW_TRIG];
                cmp_en_q <= WDATA_I[`BIT_CMP_EN];
                cmp_ge_q <= WDATA_I[`BIT_CMP_GE];
            end
            if (wr_cfg) begin
                mode_q <= WDATA_I[3:2];
                src_q <= WDATA_I[1:0];
            end
            if (wr_cvh) begin
                cv_q[11:8] <= WDATA_I[3:0];
            end
            if (wr_cvl) begin
                cv_q[7:0] <= WDATA_I;
            end
        end
    end

    // read mux, answered in the following cycle
    logic [7:0] rmux;
    always_comb begin
        case (ADDR_I)
            `OFS_STAT_CTRL_1: rmux = {done_q, irq_en_q, cont_q, ch_q};
            `OFS_STAT_CTRL_2: rmux = {1'b0, trig_sel_q, cmp_en_q, cmp_ge_q, 4'h0};
            `OFS_CONFIG: rmux = {4'h0, mode_q, src_q};
            `OFS_RESULT_HIGH: rmux = {4'h0, res_q[11:8]};
            `OFS_RESULT_LOW: rmux = res_q[7:0];
            `OFS_CMP_HIGH: rmux = {4'h0, cv_q[11:8]};
            `OFS_CMP_LOW: rmux = cv_q[7:0];
            `OFS_CLOCK_GATE: rmux = {7'h00, gate_q};
            default: rmux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 8'h00;
        end else if (RD_I) begin
            rdata_q <= rmux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RDATA_O = rdata_q;
    // gate drives the module clock enable
    assign BUS_CLK_EN_O = gate_q;
    assign CONV_ACTIVE_O = (st_q == adc_ctrl_pkg::ST_CONV);
    // level interrupt from flag and enable
    assign IRQ_O = done_q & irq_en_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    gate_stops_engine_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        !gate_q |=> !CONV_ACTIVE_O)
        else $error("engine ran with clock gate off");

    pin_onehot_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        $onehot0(PIN_EN_O) && ((ch_q != 5'h04) || PIN_EN_O[4]))
        else $error("pin decode wrong");

    trig_start_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (hw_start && gate_q && !WR_I) |=> CONV_ACTIVE_O && (cnt_q == 5'h00))
        else $error("match did not start a conversion");

    single_idle_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (finish && !cont_q && !wr_sc1 && gate_q) |=> !CONV_ACTIVE_O)
        else $error("single conversion did not return idle");

    cmp_gates_done_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        ($rose(done_q) && cmp_en_q) |-> (cmp_ge_q ? (res_q >= cv_q) : (res_q < cv_q)))
        else $error("done set with compare false");

    off_stops_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (wr_sc1 && (WDATA_I[4:0] == `CH_OFF)) |=> !CONV_ACTIVE_O ##1 (!CONV_ACTIVE_O || $past(wr_sc1)))
        else $error("all-ones code left conversion running");

    write_restart_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        sw_start |=> CONV_ACTIVE_O && (cnt_q == 5'h00) && !done_q)
        else $error("control write did not restart");

    done_clear_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (rd_resl && !done_set) |=> !done_q)
        else $error("result read left done flag set");

    irq_follow_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        ($rose(done_q) && irq_en_q) |-> IRQ_O)
        else $error("interrupt missing on completion");
endmodule // adc_channel_trigger_control

// ===== logic/adc_ctrl_defs.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the converter control block.
 * assumes: included by bare name from the design files.
 */
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// ------------------------------------------------------------
// register offsets (3-bit index)
// ------------------------------------------------------------
`define OFS_STAT_CTRL_1 3'h0
`define OFS_STAT_CTRL_2 3'h1
`define OFS_CONFIG 3'h2
`define OFS_RESULT_HIGH 3'h3
`define OFS_RESULT_LOW 3'h4
`define OFS_CMP_HIGH 3'h5
`define OFS_CMP_LOW 3'h6
`define OFS_CLOCK_GATE 3'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_DONE 7
`define BIT_IRQ_EN 6
`define BIT_CONT 5
`define BIT_HW_TRIG 6
`define BIT_CMP_EN 5
`define BIT_CMP_GE 4
`define BIT_GATE 0

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define RST_CHANNEL 5'h1f
`define RST_GATE 1'b1
`define CH_OFF 5'h1f
`define CH_REF_OUT 5'h13
`define CH_BIAS 5'h17
`define CH_LEVEL_ONE 5'h18
`define CH_TEMP 5'h1a
`define CH_BANDGAP 5'h1b
`define CH_REF_HIGH 5'h1d
`define CH_REF_LOW 5'h1e
`define CH_LAST_PIN 5'h0c
`define PIN_MAP 13'h1ff1

// ------------------------------------------------------------
// timing: conversion length in conversion clock ticks
// ------------------------------------------------------------
`define CONV_TICKS 5'h11

`endif

// ===== logic/adc_ctrl_pkg.sv
/*
 * types shared by the converter control block.
 * assumes: nothing beyond the compile order.
 */
package adc_ctrl_pkg;
    // engine state
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_e;

    // conversion clock source
    typedef enum logic [1:0] {
        SRC_BUS = 2'b00,
        SRC_BUS_DIV2 = 2'b01,
        SRC_ALT = 2'b10,
        SRC_ASYNC = 2'b11
    } clk_src_e;

    // result width mode
    typedef enum logic [1:0] {
        MODE_8 = 2'b00,
        MODE_12 = 2'b01,
        MODE_10 = 2'b10,
        MODE_RSVD = 2'b11
    } res_mode_e;
endpackage

// ===== logic/conv_tick_gen.sv
/*
 * conversion clock tick generator: one enable pulse per period of the
 * selected conversion clock source.
 * assumes: alternate and async clock inputs are slow, synchronous levels.
 */
`timescale 1ns/1ps
module conv_tick_gen (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // source selection
    input wire logic [1:0] src_i,
    input wire logic async_clk_i,
    input wire logic alt_clk_i,
    // tick out
    output logic tick_o
);
    logic div_q;
    logic async_q;
    logic alt_q;
    wire async_rise = async_clk_i & ~async_q;
    wire alt_rise = alt_clk_i & ~alt_q;

    // ------------------------------------------------------------
    // divider and edge history
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 1'b0;
            async_q <= 1'b0;
            alt_q <= 1'b0;
        end else begin
            div_q <= ~div_q;
            async_q <= async_clk_i;
            alt_q <= alt_clk_i;
        end
    end

    always_comb begin
        case (adc_ctrl_pkg::clk_src_e'(src_i))
            adc_ctrl_pkg::SRC_BUS: tick_o = 1'b1;
            adc_ctrl_pkg::SRC_BUS_DIV2: tick_o = div_q;
            adc_ctrl_pkg::SRC_ALT: tick_o = alt_rise;
            adc_ctrl_pkg::SRC_ASYNC: tick_o = async_rise;
            default: tick_o = 1'b0;
        endcase
    end
endmodule // conv_tick_gen

// ===== testbench/analog_side_model.sv
/* stand-in for the analog side: channel codes, slow clocks, match pulse.
   assumes: the bench pulses fire_i for one cycle at a time. */
`timescale 1ns/1ps
module analog_side_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // from the block and the bench
    input wire logic [4:0] channel_i,
    input wire logic fire_i,
    // towards the block
    output logic [11:0] ana_o,
    output logic async_clk_o,
    output logic alt_clk_o,
    output logic match_o
);
    logic [3:0] cnt_q;
    logic match_q;
    // free-running divide-by-ten counter, clocked on the same bus clock edges used by the bench
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            match_q <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
            match_q <= fire_i;
        end
    end
    // async conversion clock keeps running in low-power modes
    assign async_clk_o = cnt_q[1];
    assign alt_clk_o = (cnt_q >= 4'h5);
    assign match_o = match_q;
    // powered-down core shows a moving pattern, not a held value
    assign ana_o = (channel_i == 5'h1f) ? {3{~cnt_q}} : {channel_i, 7'h35};
endmodule // analog_side_model

// ===== testbench/tb_top.sv
/* self-checking bench for the converter control block.
   assumes: design files compiled first; conversion length cut to 2 ticks. */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic fire = 1'b0;
    logic [7:0] rdata, d;
    logic [11:0] ana;
    logic aclk, alternate_conv_clock, match, bus_en, active, pdown, rsvd, irq;
    logic [4:0] chan;
    logic [12:0] pin_en;
    logic [6:0] int_sel;
    int miscompares = 0;
    int num_checks = 0;

    always #25 clk = ~clk;

    adc_channel_trigger_control #(.CONV_TICKS(5'h02)) u_dut (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .ASYNC_CONV_CLOCK_I(aclk),
        .EXT_REF_CLOCK_OUT_I(alternate_conv_clock), .TOD_MATCH_I(match), .ANA_DATA_I(ana),
        .BUS_CLK_EN_O(bus_en), .CONV_ACTIVE_O(active), .POWER_DOWN_O(pdown),
        .CHANNEL_O(chan), .PIN_EN_O(pin_en), .INT_SEL_O(int_sel),
        .RESERVED_O(rsvd), .IRQ_O(irq));

    analog_side_model u_model (
        .clk_i(clk), .rst_i(rst), .channel_i(chan), .fire_i(fire),
        .ana_o(ana), .async_clk_o(aclk), .alt_clk_o(alternate_conv_clock), .match_o(match));

    // ------------------------------------------------------------
    // bus and checking helpers
    // ------------------------------------------------------------
    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask

    // bounded wait so a stuck engine cannot hang the run
    task automatic wait_idle();
        int n;
        n = 0;
        while (active !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(13'(n < 200), 13'h1);
    endtask

    function automatic logic [11:0] shape(input logic [1:0] m, input logic [11:0] v);
        case (m)
            adc_ctrl_pkg::MODE_12: return v;
            adc_ctrl_pkg::MODE_10: return {2'h0, v[11:2]};
            default: return {4'h0, v[11:4]};
        endcase
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(3'h7);
        check(13'(d[0]), 13'h1);
        check(13'(bus_en), 13'h1);
        rd(3'h0);
        check(13'(d), 13'h1f);
        check(13'(pdown), 13'h1);
    endtask

    // every code decoded; software has readied the analog side
    task automatic t_decode();
        logic [12:0] pe;
        logic [6:0] isel;
        logic [4:0] ic [7] = '{5'h13, 5'h17, 5'h18, 5'h1a, 5'h1b, 5'h1d, 5'h1e};
        for (int c = 0; c < 32; c++) begin
            pe = (c == 0 || (c >= 4 && c <= 12)) ? 13'h1 << c : 13'h0;
            for (int k = 0; k < 7; k++) isel[k] = (c == ic[k]);
            wr(3'h0, 8'(c));
            check(pin_en, pe);
            check(13'(int_sel), 13'(isel));
            check(13'(rsvd), 13'(pe == 13'h0 && isel == 7'h0 && c != 31));
            wait_idle();
            rd(3'h0);
            check(13'(d[7]), 13'(c != 31));
        end
    endtask

    // all sources and widths, async source included
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 4; s++) begin
                wr(3'h2, 8'(m * 4 + s));
                wr(3'h0, 8'h04);
                wait_idle();
                check(13'(irq), 13'h0);
                rd(3'h3);
                check(13'(d), 13'(shape(2'(m), 12'h235) >> 8));
                rd(3'h4);
                check(13'(d), 13'(shape(2'(m), 12'h235) & 12'hff));
            end
        end
    endtask

    // single ends, continuous runs, all-ones stops
    task automatic t_single_cont();
        wr(3'h0, 8'h04);
        wait_idle();
        repeat (10) @(posedge clk);
        #1;
        check(13'(active), 13'h0);
        wr(3'h0, 8'h24);
        repeat (40) @(posedge clk);
        #1;
        check(13'(active), 13'h1);
        rd(3'h0);
        check(13'(d[7]), 13'h1);
        wr(3'h0, 8'h3f);
        check(13'(active), 13'h0);
        check(13'(pdown), 13'h1);
        repeat (20) @(posedge clk);
        rd(3'h0);
        check(13'(d), 13'h3f);
    endtask

    // match starts a conversion only when enabled
    task automatic t_trigger();
        logic hit;
        wr(3'h2, 8'h04);
        for (int t = 0; t < 2; t++) begin
            wr(3'h1, (t == 1) ? 8'h40 : 8'h00);
            wr(3'h0, 8'h04);
            wait_idle();
            rd(3'h4);
            @(posedge clk);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            hit = 1'b0;
            repeat (8) begin
                @(posedge clk);
                #1;
                hit = hit | active;
            end
            check(13'(hit), 13'(t));
            wait_idle();
            rd(3'h0);
            check(13'(d[7]), 13'(t));
        end
    endtask

    // compare gates the flag and the interrupt
    task automatic t_compare();
        logic [11:0] cv [3] = '{12'h300, 12'h300, 12'h235};
        logic [7:0] c2 [3] = '{8'h20, 8'h30, 8'h30};
        logic ex [3] = '{1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 3; k++) begin
            wr(3'h5, {4'h0, cv[k][11:8]});
            wr(3'h6, cv[k][7:0]);
            wr(3'h1, c2[k]);
            wr(3'h0, 8'h44);
            wait_idle();
            check(13'(irq), 13'(ex[k]));
            rd(3'h0);
            check(13'(d[7]), 13'(ex[k]));
        end
        wr(3'h0, 8'h44);
        check(13'(irq), 13'h0);
        wait_idle();
        check(13'(irq), 13'h1);
        rd(3'h4);
        check(13'(irq), 13'h0);
    endtask

    task automatic t_abort();
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h07);
        wr(3'h0, 8'h04);
        repeat (3) @(posedge clk);
        wr(3'h0, 8'h04);
        check(13'(active), 13'h1);
        rd(3'h0);
        check(13'(d[7]), 13'h0);
        wait_idle();
        rd(3'h0);
        check(13'(d[7]), 13'h1);
    endtask

    // gate off stops the clock and drops writes
    task automatic t_gate();
        wr(3'h0, 8'h04);
        wr(3'h7, 8'h00);
        check(13'(bus_en), 13'h0);
        wr(3'h0, 8'h0c);
        check(13'(active), 13'h0);
        check(13'(chan), 13'h4);
        // mid-run reset must bring the gate back
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(13'(bus_en), 13'h1);
        rd(3'h0);
        check(13'(d), 13'h1f);
        wr(3'h7, 8'h01);
        check(13'(bus_en), 13'h1);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_decode();
        t_modes();
        t_single_cont();
        t_trigger();
        t_compare();
        t_abort();
        t_gate();
        close_out();
    end

    // watchdog, well above the under one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule // tb_top
